// ==== include/shsc_pkg.sv ====
// Purpose: shared constants and types of the standby halt/stop controller
// Assumes: 10 MHz system clock
// Notes: settle select encodings are a local choice
package shsc_pkg;

  // settle select register value after reset
  localparam logic [7:0] SHSC_SETTLE_RST = 8'h04;
  // oscillator start-up interval, excluded from the settle wait
  localparam int SHSC_OSC_START_CYC = 8;
  // minimum wait from count start to halt
  localparam int SHSC_GATE_WAIT_US = 1000;
  localparam int SHSC_CLK_MHZ = 10;
  localparam int SHSC_GATE_WAIT_CYC = SHSC_GATE_WAIT_US * SHSC_CLK_MHZ;
  // settle select field width and base exponent
  localparam int SHSC_SEL_W = 3;
  localparam int SHSC_SETTLE_BASE = 4;
  localparam int SHSC_CNT_W = 24;

  // standby states, gray along run -> halt / run -> stop -> start -> settle
  typedef enum logic [2:0] {
    SHSC_RUN = 3'b000,
    SHSC_HALT = 3'b001,
    SHSC_STOP = 3'b010,
    SHSC_START = 3'b110,
    SHSC_SETTLE = 3'b111
  } shsc_state_type;

  // settle count for a select code: 2^(base+sel) cycles
  function automatic logic [SHSC_CNT_W-1:0] shsc_settle_cnt(
    input logic [7:0] sel
  );
    logic [4:0] ex;
    ex = 5'(SHSC_SETTLE_BASE) + {2'h0, sel[SHSC_SEL_W-1:0]};
    shsc_settle_cnt = SHSC_CNT_W'(1) << ex;
  endfunction

endpackage

// ==== include/shsc_if.sv ====
// Purpose: link between the standby controller and the cpu/irq side
// Assumes: one clock domain
// Notes: no clocking block
`timescale 1ns/1ns
interface shsc_if;
  logic halt_exec;
  logic stop_exec;
  logic settle_wr;
  logic [7:0] settle_wdata;
  logic irq_unmasked;
  logic nmi_req;
  logic cpu_clk_en;
  logic osc_run;
  logic periph_run;
  logic pins_hold;
  logic fc_reset;
  logic wake_vector;
  logic [7:0] osc_settle_select;

  modport dev (
    input halt_exec, stop_exec, settle_wr, settle_wdata, irq_unmasked,
    nmi_req,
    output cpu_clk_en, osc_run, periph_run, pins_hold, fc_reset,
    wake_vector, osc_settle_select
  );
  modport cpu (
    output halt_exec, stop_exec, settle_wr, settle_wdata, irq_unmasked,
    nmi_req,
    input cpu_clk_en, osc_run, periph_run, pins_hold, fc_reset,
    wake_vector, osc_settle_select
  );
endinterface

// ==== src/shsc_ctrl.sv ====
// Purpose: standby controller, device end
// Assumes: oscillator start-up is modelled by a fixed cycle count
// Notes: reset on rst_n also ends halt/stop and restarts with settling
//
// Behaviour
// RL1 - halt gates cpu clock, oscillator keeps running
// RL2 - peripherals keep running while halted
// RL3 - stop halts oscillator and whole system
// RL4 - interrupt request releases stop mode
// RL5 - settle wait after stop release, selectable
// RL6 - software writes settle select as bytes only
// RL7 - reset loads settle select with 04h
// RL8 - settle wait begins after oscillator start-up
// RL9 - stop resets counter registers, others held
// RL10 - halt keeps port outputs unchanged
// RL11 - halt lets 16-bit timer keep running
// RL12 - halt holds frequency input pins
// RL13 - halt needs 1 ms after count start
// RL14 - software stops peripherals before stop
// RL15 - software clears converter run bit first
// RL16 - unmasked interrupt ends halt
// RL17 - non-maskable interrupt ends halt
// RL18 - reset ends halt via reset vector
// RL19 - settle counter terminal set by select
// RL20 - cpu clock enabled after settle count
`timescale 1ns/1ns
module shsc_ctrl
  import shsc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link to cpu side
  shsc_if.dev link
);

  shsc_state_type state_ff;
  shsc_state_type nxt_state;
  logic [SHSC_CNT_W-1:0] cnt_ff;
  logic [SHSC_CNT_W-1:0] nxt_cnt;
  logic [7:0] sel_ff;
  logic cpu_en_ff;
  logic osc_ff;
  logic per_ff;
  logic hold_ff;
  logic fcr_ff;
  logic vec_ff;
  logic wake;

  assign wake = link.irq_unmasked | link.nmi_req; // see RL4

  ////////////////////////////////////////////////////////////////////////////
  // next state; reset itself restarts through the settle path
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      SHSC_RUN: begin
        if (link.stop_exec) begin
          nxt_state = SHSC_STOP; // see RL3
        end else if (link.halt_exec) begin
          nxt_state = SHSC_HALT; // see RL1
        end
      end
      SHSC_HALT: begin
        // either interrupt kind resumes; vectoring is the cpu's decision
        if (wake) begin
          nxt_state = SHSC_RUN; // see RL16 see RL17
        end
      end
      SHSC_STOP: begin
        if (wake) begin
          nxt_state = SHSC_START; // see RL4
          nxt_cnt = '0;
        end
      end
      SHSC_START: begin
        // start-up interval not counted toward the settle wait
        if (cnt_ff == SHSC_CNT_W'(SHSC_OSC_START_CYC - 1)) begin
          nxt_state = SHSC_SETTLE; // see RL8
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      SHSC_SETTLE: begin
        if (cnt_ff == shsc_settle_cnt(sel_ff) - 1'b1) begin
          nxt_state = SHSC_RUN; // see RL5 see RL19
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      default: begin
        nxt_state = SHSC_RUN;
        nxt_cnt = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and settle counter; reset behaves like a stop release
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= SHSC_START; // see RL18 see RL8
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // settle select, written only as a whole byte
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_ff <= SHSC_SETTLE_RST; // see RL7
    end else if (link.settle_wr) begin
      sel_ff <= link.settle_wdata; // see RL6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered controls, computed from the next state so they track it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cpu_en_ff <= 1'b0;
      osc_ff <= 1'b1;
      per_ff <= 1'b0;
      hold_ff <= 1'b0;
      fcr_ff <= 1'b1;
    end else begin
      cpu_en_ff <= (nxt_state == SHSC_RUN); // see RL1 see RL20
      osc_ff <= (nxt_state != SHSC_STOP); // see RL3
      // halted peripherals, timer included, keep running
      per_ff <= (nxt_state == SHSC_RUN) ||
                (nxt_state == SHSC_HALT); // see RL2 see RL11
      // ports and counter inputs frozen while halted
      hold_ff <= (nxt_state == SHSC_HALT); // see RL10 see RL12
      // counter registers cleared on stop entry and during reset; the rest keep state
      fcr_ff <= (nxt_state == SHSC_STOP) &&
                (state_ff != SHSC_STOP); // see RL9
    end
  end

  // flags that a reset (not an interrupt) caused the restart
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vec_ff <= 1'b1; // see RL18
    end else if (state_ff == SHSC_RUN) begin
      vec_ff <= 1'b0;
    end
  end

  assign link.cpu_clk_en = cpu_en_ff;
  assign link.osc_run = osc_ff;
  assign link.periph_run = per_ff;
  assign link.pins_hold = hold_ff;
  assign link.fc_reset = fcr_ff;
  assign link.wake_vector = vec_ff;
  assign link.osc_settle_select = sel_ff;

endmodule // shsc_ctrl

// ==== src/shsc_cpu.sv ====
// Purpose: cpu side of the standby link
// Assumes: user requests are one-cycle pulses
// Notes: delays halt until 1 ms after a count start
`timescale 1ns/1ns
module shsc_cpu
  import shsc_pkg::*;
#(
  parameter int GATE_WAIT_CYC = SHSC_GATE_WAIT_CYC
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // user requests
  input wire logic halt_req,
  input wire logic stop_req,
  input wire logic count_go,
  input wire logic periph_idle,
  input wire logic wr_req,
  input wire logic [7:0] wr_data,
  input wire logic irq_in,
  input wire logic nmi_in,
  // user status
  output logic running,
  output logic converter_run_bit,
  // link
  shsc_if.cpu link
);

  logic [15:0] gate_ff;
  logic halt_pend_ff;
  logic halt_ff;
  logic stop_ff;
  logic wr_ff;
  logic [7:0] wd_ff;
  logic irq_ff;
  logic nmi_ff;
  logic run_ff;
  logic conv_ff;

  ////////////////////////////////////////////////////////////////////////////
  // gate wait counter started by a count start
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gate_ff <= '0;
    end else if (count_go) begin
      gate_ff <= 16'(GATE_WAIT_CYC); // see RL13
    end else if (gate_ff != '0) begin
      gate_ff <= gate_ff - 1'b1;
    end
  end

  // instruction issue; stop issues only with idle peripherals, else is dropped
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      halt_pend_ff <= 1'b0;
      halt_ff <= 1'b0;
      stop_ff <= 1'b0;
      conv_ff <= 1'b0;
    end else begin
      halt_ff <= 1'b0;
      stop_ff <= 1'b0;
      // converter restarts only once the cpu runs with no standby pending,
      // so a request that is dropped does not leave it off for good
      if (halt_req || stop_req) begin
        conv_ff <= 1'b0; // see RL15
      end else if (link.cpu_clk_en && !halt_pend_ff && !halt_ff &&
                   !stop_ff) begin
        conv_ff <= 1'b1;
      end
      if (halt_req) begin
        halt_pend_ff <= 1'b1;
      end else if (halt_pend_ff && gate_ff == '0 && link.cpu_clk_en) begin
        halt_ff <= 1'b1; // see RL13
        halt_pend_ff <= 1'b0;
      end
      if (stop_req && periph_idle && link.cpu_clk_en) begin
        stop_ff <= 1'b1; // see RL14
      end
    end
  end

  // byte write path and interrupt lines
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ff <= 1'b0;
      wd_ff <= 8'h00;
      irq_ff <= 1'b0;
      nmi_ff <= 1'b0;
      run_ff <= 1'b0;
    end else begin
      wr_ff <= wr_req; // see RL6
      wd_ff <= wr_data;
      irq_ff <= irq_in;
      nmi_ff <= nmi_in;
      run_ff <= link.cpu_clk_en;
    end
  end

  assign link.halt_exec = halt_ff;
  assign link.stop_exec = stop_ff;
  assign link.settle_wr = wr_ff;
  assign link.settle_wdata = wd_ff;
  assign link.irq_unmasked = irq_ff;
  assign link.nmi_req = nmi_ff;
  assign running = run_ff;
  assign converter_run_bit = conv_ff;

endmodule // shsc_cpu

// ==== dv/shsc_sva.sv ====
// Purpose: interface checks of the standby controller link
// Assumes: one clock domain, settle select codes 04h and 00h in use
// Notes: settle length is checked here only for the reset select value
`timescale 1ns/1ns
module shsc_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // cpu side requests
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic settle_wr,
  input wire logic [7:0] settle_wdata,
  input wire logic irq_unmasked,
  input wire logic nmi_req,
  // controller outputs
  input wire logic cpu_clk_en,
  input wire logic osc_run,
  input wire logic periph_run,
  input wire logic pins_hold,
  input wire logic fc_reset,
  input wire logic [7:0] osc_settle_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // halt entry, hold and release; stop wins, so it is excluded here
  chk_halt_gates: assert property (
    cpu_clk_en && halt_exec && !stop_exec |=>
    !cpu_clk_en && osc_run && pins_hold) else $error("halt entry wrong");
  chk_halt_hold: assert property (
    pins_hold |-> periph_run && osc_run && !cpu_clk_en)
    else $error("halt state wrong");
  chk_halt_wake: assert property (
    pins_hold && (irq_unmasked || nmi_req) |=> cpu_clk_en && !pins_hold)
    else $error("halt not released");
  ////////////////////////////////////////////////////////////////////////////
  // stop entry, quiet state and wake-up timing
  chk_stop_entry: assert property (
    cpu_clk_en && stop_exec |=> !osc_run && !periph_run && fc_reset
    ##1 !fc_reset) else $error("stop entry wrong");
  chk_stop_quiet: assert property (
    !osc_run |-> !periph_run && !cpu_clk_en && !pins_hold)
    else $error("stop state wrong");
  chk_stop_wake: assert property (
    !osc_run && irq_unmasked |=> osc_run) else $error("stop not released");
  chk_start_wait: assert property (
    $rose(osc_run) |-> !cpu_clk_en [*8]) else $error("cpu clock too early");
  chk_settle_len: assert property (
    $rose(osc_run) && osc_settle_select == 8'h04 |-> ##[262:266] cpu_clk_en)
    else $error("settle wait wrong");
  ////////////////////////////////////////////////////////////////////////////
  // byte write of the settle select
  chk_sel_write: assert property (
    cpu_clk_en && settle_wr |=> osc_settle_select == $past(settle_wdata))
    else $error("select write lost");
endmodule // shsc_sva

// ==== dv/testbench.sv ====
// Purpose: both ends of the standby link driven from the cpu user side
// Assumes: 10 MHz clock, gate wait shortened to 20 cycles
// Notes: stop wake length is measured from oscillator restart
`timescale 1ns/1ns
module testbench;
  import shsc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic halt_req = 1'b0, stop_req = 1'b0, count_go = 1'b0;
  logic periph_idle = 1'b0, wr_req = 1'b0, irq_in = 1'b0, nmi_in = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic running, converter_run_bit;
  int n_errors = 0;
  int cmp_count = 0;
  shsc_if lnk ();
  shsc_ctrl shsc_ctrl_i (.clock(clock), .rst_n(rst_n), .link(lnk));
  shsc_cpu #(.GATE_WAIT_CYC(20)) shsc_cpu_i (.clock(clock), .rst_n(rst_n),
    .halt_req(halt_req), .stop_req(stop_req), .count_go(count_go),
    .periph_idle(periph_idle), .wr_req(wr_req), .wr_data(wr_data),
    .irq_in(irq_in), .nmi_in(nmi_in), .running(running),
    .converter_run_bit(converter_run_bit), .link(lnk));
  shsc_sva shsc_sva_i (.clock(clock), .rst_n(rst_n),
    .halt_exec(lnk.halt_exec), .stop_exec(lnk.stop_exec),
    .settle_wr(lnk.settle_wr), .settle_wdata(lnk.settle_wdata),
    .irq_unmasked(lnk.irq_unmasked), .nmi_req(lnk.nmi_req),
    .cpu_clk_en(lnk.cpu_clk_en), .osc_run(lnk.osc_run),
    .periph_run(lnk.periph_run), .pins_hold(lnk.pins_hold),
    .fc_reset(lnk.fc_reset), .osc_settle_select(lnk.osc_settle_select));
  ////////////////////////////////////////////////////////////////////////////
  // clock and shared helpers; inputs move 1 ns after the rising edge
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait on oscillator (sel 1) or cpu clock enable; returns cycles
  task automatic wait_sig(input bit sel, input logic v, output int n);
    n = 0;
    while ((sel ? lnk.osc_run : lnk.cpu_clk_en) !== v) begin
      tick(1);
      n++;
      if (n > 2000) begin
        n_errors++;
        end_sim();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    int n;
    int exp_n;
    exp_n = SHSC_OSC_START_CYC +
      (1 << (SHSC_SETTLE_BASE + SHSC_SETTLE_RST[2:0]));
    chk(lnk.osc_settle_select, 16'h0004);
    chk({lnk.pins_hold, lnk.wake_vector}, 16'h1);
    wait_sig(1'b0, 1'b1, n);
    chk(16'(n), 16'(exp_n));
    tick(1);
    chk({running, lnk.wake_vector}, 16'h2);
  endtask
  // halt soon after a count start is held off, then woken by irq or nmi
  task automatic t_halt(input bit use_nmi);
    int n;
    count_go = 1'b1;
    tick(1);
    count_go = 1'b0;
    halt_req = 1'b1;
    tick(1);
    halt_req = 1'b0;
    tick(10);
    chk(lnk.cpu_clk_en, 16'h1);
    wait_sig(1'b0, 1'b0, n);
    chk({lnk.osc_run, lnk.periph_run, lnk.pins_hold}, 16'h7);
    chk(converter_run_bit, 16'h0);
    if (use_nmi) nmi_in = 1'b1;
    else irq_in = 1'b1;
    wait_sig(1'b0, 1'b1, n);
    nmi_in = 1'b0;
    irq_in = 1'b0;
    chk(lnk.pins_hold, 16'h0);
    tick(2);
  endtask
  // stop with a chosen settle select, woken by irq, wait measured
  task automatic t_stop(input logic [7:0] sel);
    int n;
    wr_data = sel;
    wr_req = 1'b1;
    tick(1);
    wr_req = 1'b0;
    tick(3);
    chk(lnk.osc_settle_select, {8'h00, sel});
    periph_idle = 1'b1;
    stop_req = 1'b1;
    tick(1);
    stop_req = 1'b0;
    wait_sig(1'b1, 1'b0, n);
    chk({lnk.periph_run, lnk.cpu_clk_en}, 16'h0);
    chk(converter_run_bit, 16'h0);
    irq_in = 1'b1;
    wait_sig(1'b1, 1'b1, n);
    irq_in = 1'b0;
    wait_sig(1'b0, 1'b1, n);
    n = n - SHSC_OSC_START_CYC; // start-up interval is not part of it
    chk(16'(n), 16'(1 << (SHSC_SETTLE_BASE + sel[2:0])));
    periph_idle = 1'b0;
    tick(2);
  endtask
  // reset while halted ends the halt and restarts through the settle wait
  task automatic t_halt_reset();
    int n;
    halt_req = 1'b1;
    tick(1);
    halt_req = 1'b0;
    wait_sig(1'b0, 1'b0, n);
    chk(lnk.pins_hold, 16'h1);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    t_reset();
  endtask
  // stop is dropped while peripherals are still busy
  task automatic t_stop_busy();
    stop_req = 1'b1;
    tick(1);
    stop_req = 1'b0;
    tick(6);
    chk(lnk.osc_run, 16'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    tick(2);
    rst_n = 1'b1;
    t_reset();
    t_halt(1'b0);
    t_halt(1'b1);
    t_stop(8'h04);
    t_stop(8'h00);
    t_halt_reset();
    t_stop_busy();
    end_sim();
  end
endmodule // testbench
